// File: hdl/xdm_xtal_monitor.sv
// Purpose: Top of the crystal drift and loss monitor with APB registers.
// Assumes: All inputs are synchronous to SYS_CLK_I.
// Notes: Window counters and short-term results come from outside.
`timescale 1ns/100ps

module xdm_xtal_monitor (
	// Clock, reset and freeze.
	input wire logic SYS_CLK_I,
	input wire logic RESET_N_I,
	input wire logic CLK_EN_I,
	// APB slave.
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [xdm_pkg::ADDR_W-1:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	// Crystal clocks and external monitor results.
	input wire logic [1:0] XTAL_CLK_I,
	input wire logic [1:0] ST_FAIL_I,
	input wire xdm_pkg::xdm_window_s WINDOW_I,
	// Crystal qualification.
	output logic [1:0] XTAL_INVALID_O,
	output logic [1:0] XTAL_SELECTABLE_O,
	// Monitor status.
	output logic [1:0] LOSS_STATUS_O,
	output logic [1:0] SIGNAL_LOSS_EVENT_O,
	output logic DRIFT_WARN_O,
	output logic DRIFT_ERR_O,
	// Interrupt.
	output logic IRQ_O
);
	// Per-crystal loss configuration registers.
	xdm_pkg::xdm_loss_cfg_s loss_cfg_q [2];
	// Drift limit register.
	xdm_pkg::xdm_drift_cfg_s drift_cfg_q;
	// Sticky interrupt status and its mask.
	logic [3:0] irq_stat_q;
	logic [3:0] irq_mask_q;
	// Read data held for the access phase.
	logic [31:0] prdata_q;
	// Calibration divider.
	logic [3:0] cal_cnt_q;
	logic cal_tick;
	// Loss monitor results.
	logic [1:0] loss_sts;
	logic [1:0] loss_evt;
	// Drift results and their previous values.
	logic warn, err, warn_q, err_q;
	// Bus decode.
	logic setup, wr_en, mapped;
	logic [31:0] rd_mux;
	logic [3:0] irq_set;
	logic [3:0] irq_clr;
	// Unusable indication before registering.
	logic [1:0] invalid_d;

	// Address decode of the implemented registers.
	always_comb begin
		mapped = 1'b1;
		rd_mux = 32'h0000_0000;
		unique case (PADDR_I)
			xdm_pkg::OFF_LOSS_CFG0: begin
				rd_mux = {16'h0000, loss_cfg_q[0]};
			end
			xdm_pkg::OFF_LOSS_CFG1: begin
				rd_mux = {16'h0000, loss_cfg_q[1]};
			end
			xdm_pkg::OFF_DRIFT_CFG: begin
				rd_mux = {16'h0000, drift_cfg_q};
			end
			xdm_pkg::OFF_IRQ_STAT: begin
				rd_mux = {28'h000_0000, irq_stat_q};
			end
			xdm_pkg::OFF_IRQ_MASK: begin
				rd_mux = {28'h000_0000, irq_mask_q};
			end
			xdm_pkg::OFF_LIVE: begin
				rd_mux[xdm_pkg::LIVE_LOSS_LSB +: 2] = LOSS_STATUS_O;
				rd_mux[xdm_pkg::LIVE_INV_LSB +: 2] = XTAL_INVALID_O;
				rd_mux[xdm_pkg::LIVE_WARN] = DRIFT_WARN_O;
				rd_mux[xdm_pkg::LIVE_ERR] = DRIFT_ERR_O;
			end
			default: begin
				// Unmapped addresses read zero and answer with an error.
				mapped = 1'b0;
			end
		endcase
	end

	// The slave answers in the first access cycle unless frozen.
	assign setup = PSEL_I && !PENABLE_I && CLK_EN_I;
	assign PREADY_O = CLK_EN_I;
	assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;
	assign wr_en = PSEL_I && PENABLE_I && PWRITE_I && CLK_EN_I && mapped;
	assign PRDATA_O = prdata_q;

	// Read data is captured in the setup cycle.
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			prdata_q <= 32'h0000_0000;
		end else if (setup) begin
			prdata_q <= PWRITE_I ? 32'h0000_0000 : rd_mux;
		end
	end

	// Configuration writes; reserved bits stay zero.
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			loss_cfg_q[0] <= xdm_pkg::CFG_RESET;
			loss_cfg_q[1] <= xdm_pkg::CFG_RESET;
			drift_cfg_q <= xdm_pkg::CFG_RESET;
			irq_mask_q <= xdm_pkg::IRQ_RESET;
		end else if (wr_en) begin
			if (PADDR_I == xdm_pkg::OFF_LOSS_CFG0) begin
				loss_cfg_q[0] <= PWDATA_I[15:0] & xdm_pkg::LOSS_CFG_WMASK;
			end
			if (PADDR_I == xdm_pkg::OFF_LOSS_CFG1) begin
				loss_cfg_q[1] <= PWDATA_I[15:0] & xdm_pkg::LOSS_CFG_WMASK;
			end
			if (PADDR_I == xdm_pkg::OFF_DRIFT_CFG) begin
				drift_cfg_q <= PWDATA_I[15:0];
			end
			if (PADDR_I == xdm_pkg::OFF_IRQ_MASK) begin
				irq_mask_q <= PWDATA_I[3:0];
			end
		end
	end

	// Calibration tick, one cycle in sixteen.
	assign cal_tick = (cal_cnt_q == xdm_pkg::CAL_LAST);
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			cal_cnt_q <= 4'h0;
		end else if (CLK_EN_I) begin
			cal_cnt_q <= 4'(cal_cnt_q + 4'h1);
		end
	end

	// One missing-edge detector for each crystal.
	for (genvar i = 0; i < 2; i++) begin : g_loss
		xdm_loss_detect u_loss (
			.clk_i(SYS_CLK_I),
			.rst_n_i(RESET_N_I),
			.en_i(CLK_EN_I),
			.cal_tick_i(cal_tick),
			.xtal_i(XTAL_CLK_I[i]),
			.thresh_i(loss_cfg_q[i].los_thresh),
			.loss_sts_o(loss_sts[i]),
			.loss_evt_o(loss_evt[i])
		);
	end

	// Drift comparison between the two crystals.
	xdm_drift_check u_drift (
		.clk_i(SYS_CLK_I),
		.rst_n_i(RESET_N_I),
		.en_i(CLK_EN_I),
		.win_i(WINDOW_I),
		.cfg_i(drift_cfg_q),
		.warn_o(warn),
		.err_o(err)
	);

	// Unusable is any of blocked, unmasked loss or short-term failure.
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			invalid_d[i] = loss_cfg_q[i].xtal_disable
				| (loss_sts[i] & ~loss_cfg_q[i].los_fail_mask)
				| ST_FAIL_I[i];
		end
	end

	// Registered qualification outputs, unusable and selectable.
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			XTAL_INVALID_O <= 2'h0;
			XTAL_SELECTABLE_O <= 2'h0;
		end else if (CLK_EN_I) begin
			XTAL_INVALID_O <= invalid_d;
			XTAL_SELECTABLE_O <= ~invalid_d;
		end
	end

	// Monitor results are passed out directly from their flip-flops.
	assign LOSS_STATUS_O = loss_sts;
	assign SIGNAL_LOSS_EVENT_O = loss_evt;
	assign DRIFT_WARN_O = warn;
	assign DRIFT_ERR_O = err;

	// Previous drift flags, so that a rising flag makes one event.
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			warn_q <= 1'b0;
			err_q <= 1'b0;
		end else if (CLK_EN_I) begin
			warn_q <= warn;
			err_q <= err;
		end
	end

	// Events that set sticky bits; a set beats a same-cycle clear.
	assign irq_set[xdm_pkg::IRQ_LOSS0] = loss_evt[0];
	assign irq_set[xdm_pkg::IRQ_LOSS1] = loss_evt[1];
	assign irq_set[xdm_pkg::IRQ_WARN] = warn && !warn_q;
	assign irq_set[xdm_pkg::IRQ_ERR] = err && !err_q;
	assign irq_clr = (wr_en && PADDR_I == xdm_pkg::OFF_IRQ_STAT) ? PWDATA_I[3:0] : 4'h0;
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			irq_stat_q <= xdm_pkg::IRQ_RESET;
		end else if (CLK_EN_I) begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
		end
	end

	// Level interrupt while any unmasked status bit is set.
	assign IRQ_O = |(irq_stat_q & irq_mask_q);

	// Every property below runs on the system clock and rests in reset.
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!RESET_N_I);

	// After an enabled tick the divider must not tick again for the next eight cycles.
	property p_cal_tick;
		cal_tick && CLK_EN_I |=> !cal_tick [*8];
	endproperty
	a_cal_tick: assert property (p_cal_tick) else $error("calibration tick too soon");

	// A frozen cycle leaves the divider, the status and the unusable outputs alone.
	property p_frozen;
		!CLK_EN_I |=> $stable(cal_cnt_q) && $stable(irq_stat_q) && $stable(XTAL_INVALID_O);
	endproperty
	a_frozen: assert property (p_frozen) else $error("state moved while frozen");

	// A blocked crystal is unusable and never offered as reference.
	property p_block;
		CLK_EN_I && loss_cfg_q[0].xtal_disable |=> XTAL_INVALID_O[0] && !XTAL_SELECTABLE_O[0];
	endproperty
	a_block: assert property (p_block) else $error("blocked crystal still selectable");

	// A healthy crystal that is not blocked stays on offer.
	property p_eligible;
		CLK_EN_I && !loss_cfg_q[1].xtal_disable && !loss_sts[1] && !ST_FAIL_I[1] |=> XTAL_SELECTABLE_O[1];
	endproperty
	a_eligible: assert property (p_eligible) else $error("healthy crystal not selectable");

	// After an enabled cycle the offer is the inverse of the unusable indication.
	property p_sel_inverse;
		CLK_EN_I |=> XTAL_SELECTABLE_O == ~XTAL_INVALID_O;
	endproperty
	a_sel_inverse: assert property (p_sel_inverse) else $error("offer and unusable disagree");

	// Loss reaches the unusable flag only while it is unmasked.
	property p_loss_mask;
		CLK_EN_I && loss_sts[0] |=> XTAL_INVALID_O[0] == !$past(loss_cfg_q[0].los_fail_mask)
			|| $past(loss_cfg_q[0].xtal_disable || ST_FAIL_I[0]);
	endproperty
	a_loss_mask: assert property (p_loss_mask) else $error("loss mask not honoured");

	// Unmasked loss on its own makes the crystal unusable.
	property p_loss_invalid;
		CLK_EN_I && loss_sts[1] && !loss_cfg_q[1].los_fail_mask |=> XTAL_INVALID_O[1];
	endproperty
	a_loss_invalid: assert property (p_loss_invalid) else $error("unmasked loss not shown");

	// With none of the three causes present the crystal is usable.
	property p_invalid_causes;
		CLK_EN_I && !loss_cfg_q[0].xtal_disable && !ST_FAIL_I[0]
			&& !(loss_sts[0] && !loss_cfg_q[0].los_fail_mask) |=> !XTAL_INVALID_O[0];
	endproperty
	a_invalid_causes: assert property (p_invalid_causes) else $error("crystal unusable with no cause");

	// A short-term failure is shown one cycle later.
	property p_st_fail;
		CLK_EN_I && ST_FAIL_I[1] |=> XTAL_INVALID_O[1];
	endproperty
	a_st_fail: assert property (p_st_fail) else $error("short-term failure not shown");

	// Every loss event is kept in the sticky status.
	property p_irq_sticky;
		CLK_EN_I && loss_evt[1] |=> irq_stat_q[xdm_pkg::IRQ_LOSS1];
	endproperty
	a_irq_sticky: assert property (p_irq_sticky) else $error("loss event lost from status");

	// An enabled, unmasked loss event raises the interrupt line.
	property p_irq_out;
		CLK_EN_I && !wr_en && loss_evt[0] && irq_mask_q[xdm_pkg::IRQ_LOSS0] |=> IRQ_O;
	endproperty
	a_irq_out: assert property (p_irq_out) else $error("unmasked loss gave no interrupt");

	// An error rise is kept even when a clear lands in the same cycle.
	property p_set_wins;
		CLK_EN_I && irq_set[xdm_pkg::IRQ_ERR] |=> irq_stat_q[xdm_pkg::IRQ_ERR];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("error rise lost from status");

	// A warning rise sets its own status bit.
	property p_warn_event;
		CLK_EN_I && warn && !warn_q |=> irq_stat_q[xdm_pkg::IRQ_WARN];
	endproperty
	a_warn_event: assert property (p_warn_event) else $error("warning rise lost from status");

	// Writing a one clears a warning bit when no new rise meets it.
	property p_irq_clear;
		CLK_EN_I && irq_clr[xdm_pkg::IRQ_WARN] && !irq_set[xdm_pkg::IRQ_WARN] |=> !irq_stat_q[xdm_pkg::IRQ_WARN];
	endproperty
	a_irq_clear: assert property (p_irq_clear) else $error("warning status not cleared");

	// Drift limits land as written at the end of the access.
	property p_drift_write;
		wr_en && PADDR_I == xdm_pkg::OFF_DRIFT_CFG |=> drift_cfg_q == $past(PWDATA_I[15:0]);
	endproperty
	a_drift_write: assert property (p_drift_write) else $error("drift limits not written");

	// Loss configuration keeps its reserved bits at zero when written.
	property p_loss_write;
		wr_en && PADDR_I == xdm_pkg::OFF_LOSS_CFG1 |=> loss_cfg_q[1] == $past(PWDATA_I[15:0] & xdm_pkg::LOSS_CFG_WMASK);
	endproperty
	a_loss_write: assert property (p_loss_write) else $error("loss configuration not written");

	// Read data in the access phase holds the value seen at setup.
	property p_read_mask;
		PSEL_I && PENABLE_I && !PWRITE_I && PADDR_I == xdm_pkg::OFF_IRQ_MASK && $past(CLK_EN_I)
			|-> PRDATA_O == {28'h000_0000, $past(irq_mask_q)};
	endproperty
	a_read_mask: assert property (p_read_mask) else $error("mask read back wrong");

	// Main scenarios: an interrupt, both crystals unusable, set against clear.
	c_irq: cover property (IRQ_O);
	c_block: cover property (XTAL_INVALID_O == 2'h3);
	c_set_wins: cover property (irq_set[xdm_pkg::IRQ_ERR] && irq_clr[xdm_pkg::IRQ_ERR]);
endmodule

// File: common/xdm_pkg.sv
// Purpose: Shared constants and types of the crystal drift and loss monitor.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes: Configuration registers are 16 bits wide and read zero above.
package xdm_pkg;
	// Width of the crystal window counters.
	localparam int unsigned CNT_W = 24;
	// Width of the APB address bus.
	localparam int unsigned ADDR_W = 8;
	// Register byte offsets.
	localparam logic [7:0] OFF_LOSS_CFG0 = 8'h00;
	localparam logic [7:0] OFF_DRIFT_CFG = 8'h04;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
	localparam logic [7:0] OFF_LIVE = 8'h10;
	localparam logic [7:0] OFF_LOSS_CFG1 = 8'h14;
	// Reset values and writable bits of the configuration registers.
	localparam logic [15:0] CFG_RESET = 16'h0000;
	localparam logic [15:0] LOSS_CFG_WMASK = 16'h0C7F;
	localparam logic [3:0] IRQ_RESET = 4'h0;
	// Interrupt status and mask bit positions.
	localparam int unsigned IRQ_LOSS0 = 0;
	localparam int unsigned IRQ_LOSS1 = 1;
	localparam int unsigned IRQ_WARN = 2;
	localparam int unsigned IRQ_ERR = 3;
	// Live status bit positions.
	localparam int unsigned LIVE_LOSS_LSB = 0;
	localparam int unsigned LIVE_INV_LSB = 2;
	localparam int unsigned LIVE_WARN = 4;
	localparam int unsigned LIVE_ERR = 5;
	// Calibration clock divide ratio and its counter.
	localparam int unsigned CAL_DIV = 16;
	localparam logic [3:0] CAL_LAST = 4'(CAL_DIV - 1);
	// Loss counter saturation value.
	localparam logic [6:0] LOSS_CNT_MAX = 7'h7F;

	// Loss monitor and crystal selection configuration.
	typedef struct packed {
		logic [3:0] rsvd_hi;
		logic xtal_disable;
		logic los_fail_mask;
		logic [2:0] rsvd_lo;
		logic [6:0] los_thresh;
	} xdm_loss_cfg_s;

	// Drift monitor limits, two parts per million per step.
	typedef struct packed {
		logic [7:0] err_limit;
		logic [7:0] warn_limit;
	} xdm_drift_cfg_s;

	// Crystal counters handed over at the end of a window.
	typedef struct packed {
		logic done;
		logic [CNT_W-1:0] count0;
		logic [CNT_W-1:0] count1;
	} xdm_window_s;
endpackage

// File: hdl/xdm_loss_detect.sv
// Purpose: Missing-edge detector for one crystal clock.
// Assumes: Crystal level is synchronous to the system clock.
// Notes: Counts calibration ticks between same-direction edges.
`timescale 1ns/100ps
module xdm_loss_detect (
	// Clock, reset and freeze.
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic en_i,
	// Calibration tick and crystal level.
	input wire logic cal_tick_i,
	input wire logic xtal_i,
	input wire logic [6:0] thresh_i,
	// Loss status level and event pulse.
	output logic loss_sts_o,
	output logic loss_evt_o
);
	logic xtal_q; // Previous crystal level.
	logic [6:0] rise_cnt_q; // Ticks since the last rising edge.
	logic [6:0] fall_cnt_q; // Ticks since the last falling edge.
	logic rise, fall, enabled, hit_rise, hit_fall, hit;

	// Edges and the moment a count reaches the limit.
	assign rise = xtal_i & ~xtal_q;
	assign fall = ~xtal_i & xtal_q;
	assign enabled = (thresh_i != 7'h00);
	assign hit_rise = cal_tick_i && (rise_cnt_q != xdm_pkg::LOSS_CNT_MAX) && (7'(rise_cnt_q + 7'h01) == thresh_i);
	assign hit_fall = cal_tick_i && (fall_cnt_q != xdm_pkg::LOSS_CNT_MAX) && (7'(fall_cnt_q + 7'h01) == thresh_i);
	assign hit = enabled && !rise && !fall && (hit_rise || hit_fall);

	// Two interval counters, restarted by their own edge.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			xtal_q <= 1'b0;
			rise_cnt_q <= 7'h00;
			fall_cnt_q <= 7'h00;
		end else if (en_i) begin
			xtal_q <= xtal_i;
			if (rise) begin
				rise_cnt_q <= 7'h00;
			end else if (cal_tick_i && rise_cnt_q != xdm_pkg::LOSS_CNT_MAX) begin
				rise_cnt_q <= 7'(rise_cnt_q + 7'h01);
			end
			if (fall) begin
				fall_cnt_q <= 7'h00;
			end else if (cal_tick_i && fall_cnt_q != xdm_pkg::LOSS_CNT_MAX) begin
				fall_cnt_q <= 7'(fall_cnt_q + 7'h01);
			end
		end
	end

	// Status holds until any edge; a zero limit keeps it clear.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			loss_sts_o <= 1'b0;
			loss_evt_o <= 1'b0;
		end else if (en_i) begin
			loss_evt_o <= hit;
			if (!enabled) begin
				loss_sts_o <= 1'b0;
			end else if (rise || fall) begin
				loss_sts_o <= 1'b0;
			end else if (hit) begin
				loss_sts_o <= 1'b1;
			end
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	property p_loss_edge_clears;
		en_i && enabled && (rise || fall) |=> !loss_sts_o;
	endproperty
	a_loss_edge_clears: assert property (p_loss_edge_clears) else $error("loss status kept over an edge");
	property p_loss_off;
		en_i && !enabled |=> !loss_sts_o && !loss_evt_o;
	endproperty
	a_loss_off: assert property (p_loss_off) else $error("loss raised with zero limit");
	property p_loss_evt;
		$rose(loss_evt_o) |-> loss_sts_o && $past(rise_cnt_q == 7'(thresh_i - 7'h01) || fall_cnt_q == 7'(thresh_i - 7'h01));
	endproperty
	a_loss_evt: assert property (p_loss_evt) else $error("loss event without reaching limit");
	c_loss_evt: cover property (loss_evt_o);
endmodule

// File: hdl/xdm_drift_check.sv
// Purpose: Compares the two crystal counters at each window end.
// Assumes: One counter step equals two parts per million of window.
// Notes: Flags are levels that hold until the next window end.
`timescale 1ns/100ps
module xdm_drift_check (
	// Clock, reset and freeze.
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic en_i,
	// Window counters and limits.
	input wire xdm_pkg::xdm_window_s win_i,
	input wire xdm_pkg::xdm_drift_cfg_s cfg_i,
	// Drift flags.
	output logic warn_o,
	output logic err_o
);
	logic [xdm_pkg::CNT_W-1:0] diff; // Absolute counter difference.
	logic [xdm_pkg::CNT_W-1:0] err_lim, warn_lim;
	logic over_err, over_warn;

	// Limits are compared as counts, one step being two ppm.
	assign diff = (win_i.count0 >= win_i.count1) ? win_i.count0 - win_i.count1 : win_i.count1 - win_i.count0;
	assign err_lim = xdm_pkg::CNT_W'(cfg_i.err_limit);
	assign warn_lim = xdm_pkg::CNT_W'(cfg_i.warn_limit);
	assign over_err = (cfg_i.err_limit != 8'h00) && (diff > err_lim);
	assign over_warn = (cfg_i.warn_limit != 8'h00) && (diff > warn_lim) && !over_err;

	// Flags refresh only at a window end.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			warn_o <= 1'b0;
			err_o <= 1'b0;
		end else if (en_i && win_i.done) begin
			err_o <= over_err;
			warn_o <= over_warn;
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	property p_drift_err;
		en_i && win_i.done |=> err_o == $past(cfg_i.err_limit != 8'h00 && diff > err_lim);
	endproperty
	a_drift_err: assert property (p_drift_err) else $error("error flag wrong at window end");
	property p_drift_warn;
		warn_o |-> !err_o;
	endproperty
	a_drift_warn: assert property (p_drift_warn) else $error("warning raised with error");
	property p_drift_off;
		en_i && win_i.done && cfg_i.warn_limit == 8'h00 |=> !warn_o;
	endproperty
	a_drift_off: assert property (p_drift_off) else $error("warning raised with zero limit");
	c_drift_err: cover property (err_o);
endmodule

// File: tb/xdm_xtal_src.sv
// Purpose: Behavioural model of one crystal clock source.
// Assumes: Levels change right after a system clock edge.
// Notes: A stopped crystal holds its last level, as a dead one would.
`timescale 1ns/100ps
module xdm_xtal_src (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Run control and half period in system cycles.
	input wire logic run_i,
	input wire logic [7:0] half_i,
	// Crystal level.
	output logic xtal_o
);
	// Cycles spent in the current half period.
	logic [7:0] cnt_q;
	// Present crystal level.
	logic xtal_q;

	// Toggle the level once per half period while running.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q <= 8'h00;
			xtal_q <= 1'b0;
		end else if (run_i) begin
			if (cnt_q == half_i - 8'h01) begin
				cnt_q <= 8'h00;
				xtal_q <= ~xtal_q;
			end else begin
				cnt_q <= cnt_q + 8'h01;
			end
		end
	end

	assign xtal_o = xtal_q;
endmodule

// File: tb/crystal_drift_and_loss_monitor_tb_top.sv
// Purpose: Self-checking bench of the crystal drift and loss monitor.
// Assumes: APB master with zero or more wait states.
// Notes: Crystals run at 48 system cycles, three calibration ticks.
`timescale 1ns/100ps
module crystal_drift_and_loss_monitor_tb_top;
	// Half period of each crystal in system cycles.
	localparam int HALF = 24;
	// Loss limit for an integer ratio of three, plus one.
	localparam int LIM = 4;
	// Clock, reset and enable.
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	// APB master side.
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, rerr, irq, warn, err;
	// Crystal side and qualification outputs.
	logic [1:0] run = 2'h3, st_fail = 2'h0, xtal, xtal_prev = 2'h0;
	logic [1:0] invalid, selectable, loss, evt;
	xdm_pkg::xdm_window_s win = '0;
	// Bench counters and edge bookkeeping.
	int bad_count = 0, num_checks = 0, cyc = 0;
	int evt_cnt [2] = '{0, 0};
	int last_edge [2] = '{0, 0};
	// Drift cases: limits, counters and expected warn and error.
	logic [15:0] dcfg [7] = '{16'h0A05, 16'h0A05, 16'h0A05, 16'h0A05, 16'h0005, 16'h0A00, 16'h0000};
	logic [23:0] dc0 [7] = '{24'h64, 24'h64, 24'h6F, 24'h64, 24'h0, 24'h64, 24'h0};
	logic [23:0] dc1 [7] = '{24'h6F, 24'h6E, 24'h69, 24'h69, 24'hC8, 24'h6C, 24'hFFFF};
	logic [1:0] dexp [7] = '{2'h1, 2'h2, 2'h2, 2'h0, 2'h2, 2'h0, 2'h0};

	always #20 clk = ~clk;

	xdm_xtal_monitor u_xdm_xtal_monitor (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .CLK_EN_I(clk_en),
		.PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .XTAL_CLK_I(xtal),
		.ST_FAIL_I(st_fail), .WINDOW_I(win), .XTAL_INVALID_O(invalid), .XTAL_SELECTABLE_O(selectable),
		.LOSS_STATUS_O(loss), .SIGNAL_LOSS_EVENT_O(evt), .DRIFT_WARN_O(warn), .DRIFT_ERR_O(err),
		.IRQ_O(irq));
	xdm_xtal_src u_xdm_xtal_src_0 (.clk_i(clk), .rst_n_i(rst_n), .run_i(run[0]), .half_i(8'(HALF)),
		.xtal_o(xtal[0]));
	xdm_xtal_src u_xdm_xtal_src_1 (.clk_i(clk), .rst_n_i(rst_n), .run_i(run[1]), .half_i(8'(HALF)),
		.xtal_o(xtal[1]));

	// Prints the counts and the verdict, then ends the run.
	task complete_run;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Compares a seen value with the expected one.
	task check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer; read data and error are taken at the ready edge.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Waits as long as ready takes; only the bench timeout ends a hang.
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Reads a register and compares it.
	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rd, exp);
	endtask

	// Lets registered outputs follow, then samples mid-cycle.
	task settle;
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask

	// Loss, masking, disable and short-term cases for one crystal.
	task loss_test(input int x);
		logic [7:0] a;
		int n;
		a = (x == 0) ? xdm_pkg::OFF_LOSS_CFG0 : xdm_pkg::OFF_LOSS_CFG1;
		apb(1'b1, a, 32'(LIM));
		repeat (400) @(posedge clk);
		check(loss[x], 1'b0);
		@(posedge clk) run[x] <= 1'b0;
		n = 0;
		while (loss[x] !== 1'b1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		@(negedge clk);
		n = cyc - last_edge[x];
		check(32'(n >= 16 * (LIM - 1) - HALF && n <= 16 * LIM - HALF + 3), 32'h1);
		check(evt_cnt[x], 32'h1);
		settle;
		check({invalid[x], selectable[x], irq}, 32'h4);
		rd_chk(xdm_pkg::OFF_LIVE, 32'h5 << x);
		// The other direction's counter times out too, giving a second event.
		repeat (16 * LIM) @(posedge clk);
		check(evt_cnt[x], 32'h2);
		rd_chk(xdm_pkg::OFF_IRQ_STAT, 32'h1 << x);
		apb(1'b1, xdm_pkg::OFF_IRQ_MASK, 32'h1 << x);
		settle;
		check(irq, 1'b1);
		apb(1'b1, a, 32'h0400 | LIM);
		settle;
		check({invalid[x], selectable[x]}, 32'h1);
		apb(1'b1, xdm_pkg::OFF_IRQ_STAT, 32'h1 << x);
		settle;
		check(irq, 1'b0);
		rd_chk(xdm_pkg::OFF_IRQ_STAT, 32'h0);
		check(loss[x], 1'b1);
		@(posedge clk) run[x] <= 1'b1;
		repeat (HALF + 4) @(posedge clk);
		@(negedge clk);
		check(loss[x], 1'b0);
		apb(1'b1, a, 32'h0800 | LIM);
		settle;
		check({invalid[x], selectable[x]}, 32'h2);
		apb(1'b1, a, 32'(LIM));
		st_fail[x] <= 1'b1;
		settle;
		check({invalid[x], selectable[x]}, 32'h2);
		@(posedge clk) st_fail[x] <= 1'b0;
		settle;
		check({invalid[x], selectable[x]}, 32'h1);
		apb(1'b1, a, 32'h0);
		@(posedge clk) run[x] <= 1'b0;
		repeat (2100) @(posedge clk);
		@(negedge clk);
		check({loss[x], 30'(evt_cnt[x])}, 32'h2);
		@(posedge clk) run[x] <= 1'b1;
		apb(1'b1, xdm_pkg::OFF_IRQ_MASK, 32'h0);
		$display("test loss %0d done", x);
	endtask

	// Counts event cycles, records sampled crystal edges and cuts a hang.
	always @(posedge clk) begin
		cyc++;
		for (int i = 0; i < 2; i++) begin
			if (evt[i] === 1'b1) evt_cnt[i]++;
			if (xtal[i] !== xtal_prev[i]) last_edge[i] = cyc;
		end
		xtal_prev = xtal;
		if (cyc == 40000) begin
			bad_count++;
			complete_run();
		end
	end

	// Main sequence.
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 6; i++) rd_chk(8'(4 * i), 32'h0);
		apb(1'b1, xdm_pkg::OFF_LOSS_CFG0, 32'hFFFF);
		rd_chk(xdm_pkg::OFF_LOSS_CFG0, {16'h0, xdm_pkg::LOSS_CFG_WMASK});
		apb(1'b1, xdm_pkg::OFF_LOSS_CFG0, 32'h0);
		apb(1'b1, xdm_pkg::OFF_DRIFT_CFG, 32'hFFFF);
		rd_chk(xdm_pkg::OFF_DRIFT_CFG, 32'hFFFF);
		apb(1'b0, 8'h20, 32'h0);
		check({31'h0, rerr}, 32'h1);
		check(rd, 32'h0);
		clk_en <= 1'b0;
		@(negedge clk);
		check(pready, 1'b0);
		@(posedge clk) clk_en <= 1'b1;
		$display("test registers done");
		loss_test(0);
		loss_test(1);
		for (int i = 0; i < 7; i++) begin
			apb(1'b1, xdm_pkg::OFF_DRIFT_CFG, {16'h0, dcfg[i]});
			win <= '{1'b1, dc0[i], dc1[i]};
			@(posedge clk) win.done <= 1'b0;
			settle;
			check({warn, err}, dexp[i]);
		end
		rd_chk(xdm_pkg::OFF_IRQ_STAT, 32'hC);
		apb(1'b1, xdm_pkg::OFF_IRQ_MASK, 32'h8);
		settle;
		check(irq, 1'b1);
		apb(1'b1, xdm_pkg::OFF_IRQ_STAT, 32'hF);
		settle;
		check(irq, 1'b0);
		$display("test drift done");
		complete_run();
	end
endmodule
